/* core/rcw_cfg.svh */
// constants of the reset cause and periodic wakeup block
// How it works
// - Wakeup ticks come from the 1 kHz tick or the 32 kHz tick over 32.
// - The 1 kHz wakeup source keeps counting in run, wait and stop.
// - In stop the 32 kHz source runs only if both enables were set first.
// - Wakeup control has a status flag, write-only ack and 3-bit period.
// - The wakeup interrupt is masked while its local enable is clear.
// - A period field of zero stops the timer and raises no wakeups.
// - A debug forced reset clears every reset cause flag.
// - Any write to the reset cause address restarts the watchdog only.
// - Power-on sets the power-on and low-voltage flags, clears the rest.
// - A low-voltage reset leaves only the low-voltage flag set.
// - Other resets set the flags of the sources active at entry.
// - Bit 6 reports a reset from a low level on the reset pin.
// - Bit 5 reports watchdog timeout; none occurs while disabled.
// - Bit 4 reports illegal opcode, incl. disabled stop or debug entry.
// - Bit 3 reports access to an unimplemented address.
`ifndef RCW_CFG_SVH
`define RCW_CFG_SVH
`define RCW_IDX_CAUSE    3'h0
`define RCW_IDX_WAKE     3'h1
`define RCW_IDX_IRQ_STAT 3'h2
`define RCW_IDX_IRQ_CLR  3'h3
`define RCW_IDX_IRQ_EN   3'h4
`define RCW_BIT_POR      7
`define RCW_BIT_PIN      6
`define RCW_BIT_WDOG     5
`define RCW_BIT_ILLEGAL_OPCODE_FLAG     4
`define RCW_BIT_ILLEGAL_ADDRESS_FLAG     3
`define RCW_BIT_LVD      1
`define RCW_CAUSE_POR    8'h82
`define RCW_CAUSE_LVR    8'h02
`define RCW_CAUSE_MASK   8'hfa
`define RCW_WAKE_FLAG    7
`define RCW_WAKE_ACK     6
`define RCW_WAKE_CLKSEL  5
`define RCW_WAKE_IE      4
`define RCW_WAKE_PER_HI  2
`define RCW_WAKE_PER_LO  0
`define RCW_IRQ_WAKE     0
`define RCW_IRQ_LVD      1
`define RCW_FAST_DIV     5'h1f
`define RCW_WDOG_SHORT   8'h1f
`define RCW_WDOG_LONG    8'hff
`define RCW_RST_HOLD     4'hf
`define RCW_PER1         11'h007
`define RCW_PER2         11'h01f
`define RCW_PER3         11'h03f
`define RCW_PER4         11'h07f
`define RCW_PER5         11'h0ff
`define RCW_PER6         11'h1ff
`define RCW_PER7         11'h3ff
`endif

/* core/rcw_pkg.sv */
// types of the reset cause and periodic wakeup block
package rcw_pkg;
  typedef struct packed {
    logic pin_low;
    logic opcode_unimpl;
    logic stop_instr;
    logic debug_instr;
    logic addr_unimpl;
    logic lowvolt_trip;
    logic debug_forced_reset_cmd;
  } rcw_src_t;
  typedef struct packed {
    logic lowvolt_reset_enable;
    logic lowvolt_detect_enable;
    logic lowvolt_stop_enable;
    logic watchdog_enable;
    logic watchdog_long;
    logic stop_mode_enable;
    logic debug_mode_enable;
  } rcw_cfg_t;
  typedef struct packed {
    logic       clksel;
    logic       irq_en;
    logic [2:0] period;
  } rcw_wake_t;
  typedef enum logic [1:0] {
    RCW_RUN  = 2'b00,
    RCW_HOLD = 2'b01,
    RCW_REL  = 2'b11
  } rcw_state_t;
endpackage

/* core/rcw_top.sv */
// reset cause capture, watchdog and periodic wakeup timer
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "rcw_cfg.svh"
module rcw_top (
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  input  wire logic [2:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  input  wire rcw_pkg::rcw_src_t src,
  input  wire rcw_pkg::rcw_cfg_t cfg,
  input  wire logic            tick_1k,
  input  wire logic            tick_32k,
  input  wire logic            stop_mode,
  input  wire logic            debug_active,
  output logic                 cpu_reset,
  output logic                 wakeup_req,
  output logic                 irq
);

  logic       rst_s1_r;
  logic       rst_n;
  rcw_pkg::rcw_state_t state_r;
  rcw_pkg::rcw_state_t state_nxt;
  logic [3:0] hold_r;
  logic [7:0] cause_r;
  logic [7:0] cause_nxt;
  logic       entry;
  logic       illegal_opcode_flag_hit;
  logic       lvr_hit;
  logic       wdog_hit;
  logic [7:0] wdog_cnt_r;
  logic [7:0] wdog_lim;
  logic       wdog_kick;
  logic       stop_d_r;
  logic       stop_fast_ok_r;
  logic [4:0] div_r;
  logic       fast_tick;
  logic       src_tick;
  logic       src_run;
  logic [10:0] wake_cnt_r;
  logic [10:0] wake_lim;
  logic       wake_evt;
  logic       wake_flag_r;
  rcw_pkg::rcw_wake_t wake_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic [1:0] irq_evt;
  logic       lvd_d_r;
  logic       sel_cause;
  logic       sel_wake;
  logic       sel_clr;
  logic       sel_en;
  logic       wake_wr;
  logic       ack_wr;
  logic       any_src;
  logic       irq_wake_on;
  logic       irq_lvd_on;
  logic [7:0] wake_rd;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  assign sel_cause = reg_addr == `RCW_IDX_CAUSE;
  assign sel_wake  = reg_addr == `RCW_IDX_WAKE;
  assign sel_clr   = reg_addr == `RCW_IDX_IRQ_CLR;
  assign sel_en    = reg_addr == `RCW_IDX_IRQ_EN;

  // decoded strobes shared by the register processes
  assign wake_wr   = reg_wr & sel_wake;
  assign ack_wr    = wake_wr & reg_wdata[`RCW_WAKE_ACK];

  // illegal opcode sources, stop and debug entry qualified by their enables
  assign illegal_opcode_flag_hit = src.opcode_unimpl
                  | (src.stop_instr & ~cfg.stop_mode_enable)
                  | (src.debug_instr & ~cfg.debug_mode_enable);

  // a low-voltage trip resets only while its reset enable is set
  assign lvr_hit = cfg.lowvolt_reset_enable & src.lowvolt_trip;

  // causes seen while a hold runs are dropped: the cpu is already held
  assign any_src = src.pin_low | wdog_hit | illegal_opcode_flag_hit
                 | src.addr_unimpl | lvr_hit
                 | src.debug_forced_reset_cmd;

  assign entry = (state_r == rcw_pkg::RCW_RUN) & any_src;

  // cause value loaded at reset entry
  always_comb begin
    cause_nxt = 8'h00;
    if (src.debug_forced_reset_cmd) begin
      cause_nxt = 8'h00;
    end else if (lvr_hit) begin
      cause_nxt = `RCW_CAUSE_LVR;
    end else begin
      cause_nxt[`RCW_BIT_PIN]  = src.pin_low;
      cause_nxt[`RCW_BIT_WDOG] = wdog_hit;
      cause_nxt[`RCW_BIT_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag_hit;
      cause_nxt[`RCW_BIT_ILLEGAL_ADDRESS_FLAG] = src.addr_unimpl;
    end
  end

  // cause flags survive the cpu reset; only power-on and reset entry load them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= `RCW_CAUSE_POR;
    end else if (entry) begin
      cause_r <= cause_nxt & `RCW_CAUSE_MASK;
    end
  end

  // reset sequencer: hold the cpu in reset for a fixed count
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rcw_pkg::RCW_RUN: begin
        if (entry) begin
          state_nxt = rcw_pkg::RCW_HOLD;
        end
      end
      rcw_pkg::RCW_HOLD: begin
        if (hold_r == `RCW_RST_HOLD) begin
          state_nxt = rcw_pkg::RCW_REL;
        end
      end
      rcw_pkg::RCW_REL: begin
        state_nxt = rcw_pkg::RCW_RUN;
      end
      default: begin
        state_nxt = rcw_pkg::RCW_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rcw_pkg::RCW_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // hold counter restarts every time the hold state is left
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 4'h0;
    end else if (state_r == rcw_pkg::RCW_HOLD) begin
      hold_r <= hold_r + 4'h1;
    end else begin
      hold_r <= 4'h0;
    end
  end

  // taken from the next state so the cpu is held from the entry edge on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_reset <= 1'b1;
    end else begin
      cpu_reset <= state_nxt != rcw_pkg::RCW_RUN;
    end
  end

  // watchdog on the 1 kHz tick
  assign wdog_lim  = cfg.watchdog_long ? `RCW_WDOG_LONG
                                       : `RCW_WDOG_SHORT;
  assign wdog_kick = reg_wr & sel_cause;
  assign wdog_hit  = cfg.watchdog_enable & tick_1k
                   & ~debug_active
                   & (wdog_cnt_r == wdog_lim);

  // restarted by the kick, held clear for all of stop and while the cpu is held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_cnt_r <= 8'h00;
    end else if (wdog_kick | cpu_reset | stop_mode
                 | ~cfg.watchdog_enable) begin
      wdog_cnt_r <= 8'h00;
    end else if (tick_1k & ~debug_active) begin
      wdog_cnt_r <= wdog_cnt_r + 8'h01;
    end
  end

  // stop entry snapshot of the low-voltage enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_d_r <= 1'b0;
    end else begin
      stop_d_r <= stop_mode;
    end
  end

  // enables count only at stop entry; later changes wait for the next stop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_fast_ok_r <= 1'b0;
    end else if (stop_mode & ~stop_d_r) begin
      stop_fast_ok_r <= cfg.lowvolt_detect_enable
                      & cfg.lowvolt_stop_enable;
    end
  end

  // the slow tick always runs; in stop the fast one only as the snapshot allows
  assign src_run = ~stop_mode | ~wake_r.clksel
                 | stop_fast_ok_r;

  // divide the 32 kHz tick by 32 into a trimmed 1 kHz tick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 5'h00;
    end else if (tick_32k & src_run) begin
      div_r <= div_r + 5'h01;
    end
  end

  // one trimmed tick per 32 fast ticks, only while the source may run
  assign fast_tick = tick_32k & src_run
                   & (div_r == `RCW_FAST_DIV);
  assign src_tick  = wake_r.clksel ? fast_tick : tick_1k;

  // wakeup period table, in source ticks minus one
  always_comb begin
    wake_lim = 11'h000;
    unique case (wake_r.period)
      3'h1: wake_lim = `RCW_PER1;
      3'h2: wake_lim = `RCW_PER2;
      3'h3: wake_lim = `RCW_PER3;
      3'h4: wake_lim = `RCW_PER4;
      3'h5: wake_lim = `RCW_PER5;
      3'h6: wake_lim = `RCW_PER6;
      3'h7: wake_lim = `RCW_PER7;
      3'h0: wake_lim = 11'h000;
    endcase
  end

  // a zero period holds the timer idle, so no event can fire
  assign wake_evt = (wake_r.period != 3'h0) & src_tick
                  & (wake_cnt_r == wake_lim);

  // restart on each event so back to back periods stay exact
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_r <= 11'h000;
    end else if (wake_r.period == 3'h0 | wake_evt) begin
      wake_cnt_r <= 11'h000;
    end else if (src_tick) begin
      wake_cnt_r <= wake_cnt_r + 11'h001;
    end
  end

  // wakeup control fields, cleared by any cpu reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= '0;
    end else if (cpu_reset) begin
      wake_r <= '0;
    end else if (wake_wr) begin
      wake_r.clksel <= reg_wdata[`RCW_WAKE_CLKSEL];
      wake_r.irq_en <= reg_wdata[`RCW_WAKE_IE];
      wake_r.period <= reg_wdata[`RCW_WAKE_PER_HI:
                                 `RCW_WAKE_PER_LO];
    end
  end

  // event flag: a new period wins over an ack in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_flag_r <= 1'b0;
    end else if (wake_evt) begin
      wake_flag_r <= 1'b1;
    end else if (cpu_reset) begin
      wake_flag_r <= 1'b0;
    end else if (ack_wr) begin
      wake_flag_r <= 1'b0;
    end
  end

  // request follows the flag but only while the local enable is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_req <= 1'b0;
    end else begin
      wakeup_req <= wake_flag_r & wake_r.irq_en;
    end
  end

  // low-voltage warning edge, only when it does not reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvd_d_r <= 1'b0;
    end else begin
      lvd_d_r <= src.lowvolt_trip;
    end
  end

  assign irq_evt[`RCW_IRQ_WAKE] = wake_evt;
  assign irq_evt[`RCW_IRQ_LVD]  = src.lowvolt_trip & ~lvd_d_r
                                & cfg.lowvolt_detect_enable
                                & ~cfg.lowvolt_reset_enable;

  // sticky status per event; set beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (reg_wr & sel_clr
                     & reg_wdata[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // enables survive a cpu reset; only power-on clears them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_r <= 2'h0;
    end else if (reg_wr & sel_en) begin
      irq_en_r <= reg_wdata[1:0];
    end
  end

  // wakeup line also needs its local enable
  assign irq_wake_on = irq_stat_r[`RCW_IRQ_WAKE]
                     & irq_en_r[`RCW_IRQ_WAKE]
                     & wake_r.irq_en;
  assign irq_lvd_on  = irq_stat_r[`RCW_IRQ_LVD]
                     & irq_en_r[`RCW_IRQ_LVD];

  // registered so the pin never glitches while the status settles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_wake_on | irq_lvd_on;
    end
  end

  // wakeup control as read back; the ack bit always reads zero
  assign wake_rd = {wake_flag_r, 1'b0,
                    wake_r.clksel, wake_r.irq_en,
                    1'b0, wake_r.period};

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `RCW_IDX_CAUSE:    reg_rdata <= cause_r;
        `RCW_IDX_WAKE:     reg_rdata <= wake_rd;
        `RCW_IDX_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_r};
        `RCW_IDX_IRQ_EN:   reg_rdata <= {6'h00, irq_en_r};
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* dv/rcw_top_monitor.sv */
// port checker of the reset cause and periodic wakeup block
`timescale 1ns/10ps
module rcw_top_monitor (
  input wire logic              ref_clk,
  input wire logic              arst_n,
  input wire logic [2:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire rcw_pkg::rcw_src_t src,
  input wire rcw_pkg::rcw_cfg_t cfg,
  input wire logic              tick_1k,
  input wire logic              tick_32k,
  input wire logic              stop_mode,
  input wire logic              debug_active,
  input wire logic              cpu_reset,
  input wire logic              wakeup_req,
  input wire logic              irq
);
  logic [7:0] wk_r;
  logic [1:0] en_r;
  logic [7:0] last_r;
  logic       rd0_r;
  logic       have_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // shadow of the wakeup control, cleared while the cpu is held
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wk_r <= 8'h00;
      en_r <= 2'h0;
    end else begin
      if (cpu_reset) wk_r <= 8'h00;
      else if (reg_wr && reg_addr == 3'h1) wk_r <= reg_wdata;
      if (reg_wr && reg_addr == 3'h4) en_r <= reg_wdata[1:0];
    end
  end
  // last cause read back; forgotten once the cpu is reset again
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd0_r  <= 1'b0;
      have_r <= 1'b0;
      last_r <= 8'h00;
    end else begin
      rd0_r <= reg_rd && reg_addr == 3'h0;
      if (rd0_r) last_r <= reg_rdata;
      if (cpu_reset) have_r <= 1'b0;
      else if (rd0_r) have_r <= 1'b1;
    end
  end
  sequence s_rd0;
    reg_rd && reg_addr == 3'h0;
  endsequence
  sequence s_hold;
    ##16 cpu_reset ##1 !cpu_reset;
  endsequence
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  chk_cause_zero_bits: assert property (
    s_rd0 |=> !reg_rdata[2] && !reg_rdata[0]) else $error("cause bit set");
  chk_cause_held: assert property (
    rd0_r && have_r && !cpu_reset |-> reg_rdata == last_r)
    else $error("cause changed between resets");
  chk_hold_length: assert property (
    $rose(cpu_reset) |-> s_hold) else $error("cpu reset length wrong");
  chk_no_cause_reset: assert property (
    $rose(cpu_reset) |-> $past(src) != 7'h00 || $past(cfg.watchdog_enable))
    else $error("reset without cause");
  chk_wake_readback: assert property (
    reg_rd && reg_addr == 3'h1 && !cpu_reset |=>
      reg_rdata[6:0] == {1'b0, wk_r[5:4], 1'b0, wk_r[2:0]})
    else $error("wakeup control readback wrong");
  chk_wake_masked: assert property (
    !wk_r[4] && !$past(wk_r[4]) |-> !wakeup_req)
    else $error("wakeup while masked");
  chk_irq_masked: assert property (
    en_r == 2'h0 && $past(en_r) == 2'h0 |-> !irq)
    else $error("irq while disabled");
endmodule
bind rcw_top rcw_top_monitor i_rcw_top_monitor (.ref_clk, .arst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src, .cfg, .tick_1k, .tick_32k,
  .stop_mode, .debug_active, .cpu_reset, .wakeup_req, .irq);

/* dv/tb_top.sv */
// self-checking bench of the reset cause and periodic wakeup block
`timescale 1ns/10ps
`define CHK(nm, ex, sd) begin \
  check_count++; \
  if ((sd) !== (ex)) begin \
    error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, sd); \
  end \
end
module tb_top;
  logic              ref_clk;
  logic              arst_n;
  logic [2:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata;
  rcw_pkg::rcw_src_t src;
  rcw_pkg::rcw_cfg_t cfg;
  logic              tick_1k;
  logic              tick_32k;
  logic              stop_mode;
  logic              debug_active;
  logic              cpu_reset;
  logic              wakeup_req;
  logic              irq;
  int                error_cnt;
  int                check_count;
  int                cyc_cnt;
  int                seed;
  logic [7:0]        d;
  logic [7:0]        cause;
  logic [8:0]        e;
  logic [13:0]       sc;
  logic [13:0]       corner [13];
  rcw_top i_rcw_top (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .src, .cfg, .tick_1k, .tick_32k, .stop_mode,
    .debug_active, .cpu_reset, .wakeup_req, .irq);
  // bit 8 says whether a reset is taken, bits 7:0 the cause it leaves
  function automatic logic [8:0] exp_cause(rcw_pkg::rcw_src_t s,
                                           rcw_pkg::rcw_cfg_t c);
    logic illegal_opcode_flag;
    illegal_opcode_flag = s.opcode_unimpl | s.stop_instr & !c.stop_mode_enable |
           s.debug_instr & !c.debug_mode_enable;
    if (s.debug_forced_reset_cmd) return 9'h100;
    if (s.lowvolt_trip && c.lowvolt_reset_enable) return 9'h102;
    return {s.pin_low | illegal_opcode_flag | s.addr_unimpl,
            1'b0, s.pin_low, 1'b0, illegal_opcode_flag, s.addr_unimpl, 3'h0};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    // data stand until the next edge; take them there, before they drop
    @(posedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic tick(input bit fast, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tick_1k <= !fast;
      tick_32k <= fast;
      @(posedge ref_clk);
      tick_1k <= 1'b0;
      tick_32k <= 1'b0;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // the whole run needs some 3500 cycles
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, src, cfg} = '0;
    {tick_1k, tick_32k, stop_mode, debug_active, arst_n} = '0;
    {error_cnt, check_count, cyc_cnt} = '0;
    seed = 61109;
    corner = '{14'h2000, 14'h1000, 14'h0800, 14'h0802, 14'h0400, 14'h0401,
      14'h0200, 14'h0140, 14'h0120, 14'h0080, 14'h22c0, 14'h2340, 14'h2200};
    cyc(16);
    arst_n <= 1'b1;
    cyc(3);
    rd(3'h0, d);
    `CHK("por cause", 8'h82, d)
    rd(3'h7, d);
    `CHK("unmapped", 8'h00, d)
    wr(3'h0, 8'($random(seed)));
    rd(3'h0, d);
    `CHK("cause after write", 8'h82, d)
    cause = 8'h82;
    for (int i = 0; i < 25; i++) begin
      sc = corner[i % 13];
      if (i >= 13) sc = {7'($random(seed) & $random(seed)),
                         7'($random(seed)) & 7'h77};
      e = exp_cause(sc[13:7], sc[6:0]);
      @(posedge ref_clk);
      cfg <= sc[6:0];
      src <= sc[13:7];
      @(posedge ref_clk);
      src <= 7'h00;
      #1;
      `CHK("reset taken", e[8], cpu_reset)
      if (e[8]) cause = e[7:0];
      cyc(20);
      rd(3'h0, d);
      `CHK("cause", cause, d)
    end
    for (int i = 0; i < 2; i++) begin
      cfg <= {3'h0, 1'b1, i[0], 2'h0};
      wr(3'h0, 8'($random(seed)));
      tick(0, i ? 255 : 31);
      wr(3'h0, 8'($random(seed)));
      tick(0, i ? 255 : 31);
      `CHK("wdog early", 1'b0, cpu_reset)
      tick(0, 1);
      cyc(2);
      `CHK("wdog reset", 1'b1, cpu_reset)
      cfg <= 7'h00;
      cyc(20);
      rd(3'h0, d);
      `CHK("wdog cause", 8'h20, d)
    end
    wr(3'h4, 8'h01);
    // drop low-voltage warnings left over from the cause scenarios
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h11);
    tick(0, 7);
    `CHK("early wake", 1'b0, wakeup_req)
    tick(0, 1);
    cyc(2);
    `CHK("wake", 1'b1, wakeup_req)
    `CHK("irq", 1'b1, irq)
    rd(3'h2, d);
    `CHK("irq status", 8'h01, d)
    rd(3'h4, d);
    `CHK("irq enable", 8'h01, d)
    rd(3'h1, d);
    `CHK("wake ctl", 8'h91, d)
    wr(3'h1, 8'h51);
    wr(3'h3, 8'h01);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    wr(3'h1, 8'h01);
    tick(0, 8);
    cyc(2);
    `CHK("masked wake", 1'b0, wakeup_req)
    `CHK("masked irq", 1'b0, irq)
    rd(3'h1, d);
    `CHK("masked flag", 8'h81, d)
    wr(3'h1, 8'h50);
    tick(0, 16);
    rd(3'h1, d);
    `CHK("timer off", 8'h10, d)
    // stop without both low-voltage enables freezes the 32 kHz divider
    for (int i = 0; i < 3; i++) begin
      cfg <= (i == 1) ? 7'h30 : 7'h00;
      wr(3'h1, 8'h71);
      stop_mode <= (i < 2);
      tick(1, 255);
      `CHK("early 32k wake", 1'b0, wakeup_req)
      tick(1, 1);
      cyc(2);
      `CHK("32k wake", i != 0, wakeup_req)
      stop_mode <= 1'b0;
    end
    test_done();
  end
endmodule
